// File: msq_dp_model.sv
// data path stand-in: instruction fetch by program counter, branch and
// fork conditions, result flags; assumes the sequencer samples at t3
module msq_dp_model #(
   parameter logic [15:0] INSTR0 = 16'h8A00
) (
   input  wire         clk,
   input  wire  [15:0] pc,
   input  wire  [31:0] cond_pat,
   input  wire  [2:0]  fork_pat,
   output logic [15:0] instr_data,
   output logic [31:0] cond_in,
   output logic [2:0]  fork_cond,
   output logic [3:0]  flags
);
   // other addresses fetch a different word, so a stale pc shows up
   assign instr_data = (pc == 16'h0000) ? INSTR0 : ~INSTR0;
   always @(posedge clk) begin
      cond_in <= cond_pat;
      fork_cond <= fork_pat;
      flags <= cond_pat[3:0];
   end
endmodule

// File: msq_fork.v
// one fork: combinational decode of an instruction, an operand mode and a
// class code into an address mask; assumes inputs settle within one phase
`include "msq_map.vh"
module msq_fork #(
   parameter MODE_LSB = 9
) (
   input  wire        en,
   input  wire [15:0] instr,
   input  wire [2:0]  cls,
   input  wire        cond,
   output reg  [7:0]  mask
);
   always @* begin
      // all ones leaves the address untouched while disabled
      mask = 8'hFF;
      if (en) begin
         mask = {1'b1, cond, instr[MODE_LSB+2:MODE_LSB], cls};
      end
   end
endmodule

// File: msq_map.vh
// constants for the microsequencer: control word layout, register offsets,
// reset values and phase timing; included by every design file of the block
`ifndef MSQ_MAP_VH
`define MSQ_MAP_VH

// control word geometry
`define MSQ_ADDR_W        8
`define MSQ_WORD_W        64
`define MSQ_HALF_W        32
`define MSQ_HALVES        2
// 27 fields in all; only those the sequencer itself reads are named here
`define MSQ_CW_MSB        63
`define MSQ_CW_LSB        15
`define MSQ_T2_LSB        46
`define MSQ_F_IRK         46
`define MSQ_F_PCA         51
`define MSQ_F_CCL_MSB     54
`define MSQ_F_CCL_LSB     52
`define MSQ_F_FEN_C       14
`define MSQ_F_FEN_B       13
`define MSQ_F_FEN_A       12
`define MSQ_F_BEF_MSB     11
`define MSQ_F_BEF_LSB     8
`define MSQ_F_UAD_MSB     7
`define MSQ_F_UAD_LSB     0

// machine cycle: one clock per phase, t1 t2 t3 then a spare phase
`define MSQ_PHASES        4
`define MSQ_PH_T1         2'h0
`define MSQ_PH_T2         2'h1
`define MSQ_PH_T3         2'h2
`define MSQ_PH_IDLE       2'h3

// reset values and program counter step
`define MSQ_POWERUP_UADDR 8'h00
`define MSQ_POWERUP_PC    16'h0000
`define MSQ_PC_STEP       16'h0002

// apb register offsets (byte addresses), control run bit and control reset value
`define MSQ_REG_CTRL      8'h00
`define MSQ_REG_STATUS    8'h04
`define MSQ_REG_UC_ADDR   8'h08
`define MSQ_REG_UC_LO     8'h0C
`define MSQ_REG_UC_HI     8'h10
`define MSQ_REG_IR        8'h14
`define MSQ_REG_CC        8'h18
`define MSQ_CTRL_RUN_BIT  0
`define MSQ_CTRL_RESET    32'h0000_0001

`endif

// File: msq_seq.v
// microprogram sequencer: control store, word buffer, address register
// copies, branch and fork address logic, instruction and flag registers.
// assumes apb master and data path logic on CLK; no pin inputs.
`include "msq_map.vh"
module msq_seq (
   input  wire        CLK,
   input  wire        RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire [15:0] INSTR_DATA,
   input  wire [31:0] COND_IN,
   input  wire [2:0]  FORK_COND,
   input  wire        ALU_N,
   input  wire        ALU_Z,
   input  wire        ALU_V,
   input  wire        ALU_C,
   output wire [48:0] CTRL_WORD,
   output wire        PHASE_ONE_PULSE,
   output wire        PHASE_TWO_PULSE,
   output wire        PHASE_THREE_PULSE,
   output wire [7:0]  MMU_ADDR,
   output wire [15:0] IR_OUT,
   output wire [15:0] PC_OUT,
   output wire [3:0]  CC_OUT,
   output wire [1:0]  CC_SEL,
   output wire        FORK_ERR
);

   // subsidiary decode: operation class of an instruction
   function [2:0] sub_class;
      input [15:0] ins;
      begin
         if (ins[14:12] == 3'h0) begin
            sub_class = {1'b1, ins[15], ins[11]};
         end else begin
            sub_class = {1'b0, ins[13:12]};
         end
      end
   endfunction

   // flag interpretation: 0 arithmetic, 1 logical, 2 special
   function [1:0] cc_class;
      input [15:0] ins;
      begin
         case (ins[14:12])
            3'h0:    cc_class = 2'h2;
            3'h1,
            3'h3,
            3'h4,
            3'h5:    cc_class = 2'h1;
            default: cc_class = 2'h0;
         endcase
      end
   endfunction

   reg  [1:0]               phase_r;
   reg  [31:0]              ctrl_r;
   reg  [7:0]               uc_addr_r;
   reg  [31:0]              uc_lo_r;
   reg  [`MSQ_CW_MSB:`MSQ_CW_LSB] cwb_r;
   reg  [15:0]              ir_r;
   reg  [15:0]              fork_a_instr_copy_r;
   reg  [15:0]              pc_r;
   reg  [3:0]               cc_r;
   reg  [3:0]               cc_nxt;
   reg  [1:0]               br_mod;
   wire [`MSQ_WORD_W-1:0]   rom_q;
   wire                     run;
   wire                     t1;
   wire                     t2;
   wire                     t3;
   wire                     wr_acc;
   wire                     rd_setup;
   wire                     addr_ok;
   wire                     uc_we;
   wire [7:0]               control_address_reg [0:2];
   wire [2:0]               fork_en;
   wire [3:0]               bef;
   wire [7:0]               next_addr_field;
   wire [7:0]               mask_a;
   wire [7:0]               mask_b;
   wire [7:0]               mask_c;
   wire [7:0]               next_addr;
   wire [2:0]               ir_cls;
   wire [2:0]               fork_a_instr_copy_cls;

   // ---------------- apb slave, zero wait states
   assign PREADY   = 1'b1;
   assign addr_ok  = (PADDR == `MSQ_REG_CTRL)    || (PADDR == `MSQ_REG_STATUS) ||
                     (PADDR == `MSQ_REG_UC_ADDR) || (PADDR == `MSQ_REG_UC_LO)  ||
                     (PADDR == `MSQ_REG_UC_HI)   || (PADDR == `MSQ_REG_IR)     ||
                     (PADDR == `MSQ_REG_CC);
   assign PSLVERR  = PSEL & PENABLE & ~addr_ok;
   assign wr_acc   = PSEL & PENABLE & PWRITE & addr_ok;
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
   assign uc_we    = wr_acc & (PADDR == `MSQ_REG_UC_HI);
   assign run      = ctrl_r[`MSQ_CTRL_RUN_BIT];

   always @(posedge CLK) begin
      if (RST) begin
         ctrl_r    <= `MSQ_CTRL_RESET;
         uc_addr_r <= 8'h00;
         uc_lo_r   <= 32'h0000_0000;
      end else if (wr_acc) begin
         case (PADDR)
            `MSQ_REG_CTRL:    ctrl_r    <= PWDATA;
            `MSQ_REG_UC_ADDR: uc_addr_r <= PWDATA[7:0];
            `MSQ_REG_UC_LO:   uc_lo_r   <= PWDATA;
            // storing the upper half commits the word and steps the load pointer
            `MSQ_REG_UC_HI:   uc_addr_r <= uc_addr_r + 8'h01;
            default:          uc_lo_r   <= uc_lo_r;
         endcase
      end
   end

   // read data sampled in setup so it is a flop output during access
   always @(posedge CLK) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (PADDR)
            `MSQ_REG_CTRL:    PRDATA <= ctrl_r;
            `MSQ_REG_STATUS:  PRDATA <= {pc_r, 5'h00, FORK_ERR, phase_r, control_address_reg[2]};
            `MSQ_REG_UC_ADDR: PRDATA <= {24'h000000, uc_addr_r};
            `MSQ_REG_UC_LO:   PRDATA <= uc_lo_r;
            `MSQ_REG_IR:      PRDATA <= {fork_a_instr_copy_r, ir_r};
            `MSQ_REG_CC:      PRDATA <= {26'h0000000, CC_SEL, cc_r};
            default:          PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------- phase generator: t1, t2, t3 enables
   // stopping run freezes the sequence at a cycle boundary for loading
   always @(posedge CLK) begin
      if (RST) begin
         phase_r <= `MSQ_PH_IDLE;
      end else if (run || phase_r != `MSQ_PH_IDLE) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   // phase leaves idle only while running, so clearing run still ends the cycle
   assign t1 = (phase_r == `MSQ_PH_T1);
   assign t2 = (phase_r == `MSQ_PH_T2);
   assign t3 = (phase_r == `MSQ_PH_T3);
   assign PHASE_ONE_PULSE   = t1;
   assign PHASE_TWO_PULSE   = t2;
   assign PHASE_THREE_PULSE = t3;

   // ---------------- address register copies
   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1) begin : g_rar
         reg [7:0] q_r;
         always @(posedge CLK) begin
            if (RST) begin
               q_r <= `MSQ_POWERUP_UADDR;
            end else if (t3) begin
               q_r <= next_addr;
            end
         end
         assign control_address_reg[k] = q_r;
      end
   endgenerate

   assign MMU_ADDR = control_address_reg[2];

   // ---------------- control store, one slice per word half, read by address copies 0 and 1
   generate
      for (k = 0; k < `MSQ_HALVES; k = k + 1) begin : g_store
         msq_store #(
            .WIDTH (`MSQ_HALF_W),
            .AW    (`MSQ_ADDR_W)
         ) u_store (
            .clk   (CLK),
            .rst   (RST),
            .we    (uc_we),
            .waddr (uc_addr_r),
            .wdata ((k == 0) ? uc_lo_r : PWDATA),
            .raddr (control_address_reg[k]),
            .rdata (rom_q[k*`MSQ_HALF_W +: `MSQ_HALF_W])
         );
      end
   endgenerate

   // ---------------- control word buffer
   // t1 group settles early for data paths; t2 group can wait until t3
   always @(posedge CLK) begin
      if (RST) begin
         cwb_r <= {(`MSQ_CW_MSB-`MSQ_CW_LSB+1){1'b0}};
      end else begin
         if (t1) begin
            cwb_r[`MSQ_T2_LSB-1:`MSQ_CW_LSB] <= rom_q[`MSQ_T2_LSB-1:`MSQ_CW_LSB];
         end
         if (t2) begin
            cwb_r[`MSQ_CW_MSB:`MSQ_T2_LSB] <= rom_q[`MSQ_CW_MSB:`MSQ_T2_LSB];
         end
      end
   end

   assign CTRL_WORD = cwb_r;

   // ---------------- unbuffered next-address fields
   assign fork_en = rom_q[`MSQ_F_FEN_C:`MSQ_F_FEN_A];
   assign bef     = rom_q[`MSQ_F_BEF_MSB:`MSQ_F_BEF_LSB];
   assign next_addr_field     = rom_q[`MSQ_F_UAD_MSB:`MSQ_F_UAD_LSB];

   // ---------------- branch logic
   // select 0 gives none, other low selects give one modifier, high selects give a pair
   always @* begin
      br_mod = 2'h0;
      if (bef != 4'h0) begin
         br_mod[0] = COND_IN[{bef, 1'b0}];
         if (bef[3]) begin
            br_mod[1] = COND_IN[{bef, 1'b1}];
         end
      end
   end

   // ---------------- forks
   assign fork_a_instr_copy_cls = {1'b0, fork_a_instr_copy_r[15:14]};
   assign ir_cls   = sub_class(ir_r);

   msq_fork #(
      .MODE_LSB (9)
   ) u_fork_a (
      .en    (fork_en[0]),
      .instr (fork_a_instr_copy_r),
      .cls   (fork_a_instr_copy_cls),
      .cond  (FORK_COND[0]),
      .mask  (mask_a)
   );

   msq_fork #(
      .MODE_LSB (3)
   ) u_fork_b (
      .en    (fork_en[1]),
      .instr (ir_r),
      .cls   (ir_cls),
      .cond  (FORK_COND[1]),
      .mask  (mask_b)
   );

   msq_fork #(
      .MODE_LSB (9)
   ) u_fork_c (
      .en    (fork_en[2]),
      .instr (ir_r),
      .cls   (ir_cls),
      .cond  (FORK_COND[2]),
      .mask  (mask_c)
   );

   // disabled forks give all ones, so a lone field passes unchanged
   assign next_addr = (next_addr_field | {6'h00, br_mod}) & mask_a & mask_b & mask_c;

   // microcode should never enable two forks; flagged, still masked together
   assign FORK_ERR = (fork_en[0] & fork_en[1]) | (fork_en[0] & fork_en[2]) |
                     (fork_en[1] & fork_en[2]);

   // ---------------- instruction registers and program counter
   always @(posedge CLK) begin
      if (RST) begin
         ir_r   <= 16'h0000;
         fork_a_instr_copy_r <= 16'h0000;
         pc_r   <= `MSQ_POWERUP_PC;
      end else if (t3) begin
         if (cwb_r[`MSQ_F_IRK]) begin
            ir_r   <= INSTR_DATA;
            fork_a_instr_copy_r <= INSTR_DATA;
         end
         if (cwb_r[`MSQ_F_PCA]) begin
            pc_r <= pc_r + `MSQ_PC_STEP;
         end
      end
   end

   assign IR_OUT = ir_r;
   assign PC_OUT = pc_r;

   // ---------------- condition codes {n, z, v, c}
   assign CC_SEL = cc_class(ir_r);

   always @* begin
      case (cc_class(ir_r))
         2'h0:    cc_nxt = {ALU_N, ALU_Z, ALU_V, ALU_C};
         2'h1:    cc_nxt = {ALU_N, ALU_Z, 1'b0, cc_r[0]};
         2'h2:    cc_nxt = {ALU_N, ALU_Z, cc_r[1:0]};
         default: cc_nxt = cc_r;
      endcase
   end

   always @(posedge CLK) begin
      if (RST) begin
         cc_r <= 4'h0;
      end else if (t3 && cwb_r[`MSQ_F_CCL_MSB:`MSQ_F_CCL_LSB] != 3'h0) begin
         cc_r <= cc_nxt;
      end
   end

   assign CC_OUT = cc_r;

endmodule

// File: msq_seq_chk.sv
// port checker for the microsequencer: phase order, holds, reset values
// assumes binding onto msq_seq; one clock, sync active-high reset
`include "msq_map.vh"
module msq_seq_chk (
   input wire        CLK,
   input wire        RST,
   input wire        PSEL,
   input wire        PENABLE,
   input wire [7:0]  PADDR,
   input wire        PSLVERR,
   input wire [48:0] CTRL_WORD,
   input wire        PHASE_ONE_PULSE,
   input wire        PHASE_TWO_PULSE,
   input wire        PHASE_THREE_PULSE,
   input wire [7:0]  MMU_ADDR,
   input wire [15:0] PC_OUT
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // case equality: the store is unloaded at the first run, so holds may carry x
   a_pulse_order: assert property (PHASE_ONE_PULSE |=> PHASE_TWO_PULSE ##1 PHASE_THREE_PULSE)
      else $error("phase pulses out of order");
   a_one_phase: assert property ($onehot0({PHASE_ONE_PULSE, PHASE_TWO_PULSE, PHASE_THREE_PULSE}))
      else $error("two phase pulses at once");
   a_addr_hold: assert property (!PHASE_THREE_PULSE |=> MMU_ADDR === $past(MMU_ADDR))
      else $error("microaddress moved outside third phase");
   a_ctrl_hold: assert property (!PHASE_ONE_PULSE && !PHASE_TWO_PULSE
      |=> CTRL_WORD === $past(CTRL_WORD))
      else $error("control buffer moved outside first and second phase");
   a_hi_group: assert property (PHASE_ONE_PULSE |=> CTRL_WORD[48:31] === $past(CTRL_WORD[48:31]))
      else $error("late group captured on first phase");
   a_pc_step: assert property (PHASE_THREE_PULSE && CTRL_WORD[36]
      |=> PC_OUT == $past(PC_OUT) + `MSQ_PC_STEP)
      else $error("program counter did not step");
   a_pc_hold: assert property (!(PHASE_THREE_PULSE && CTRL_WORD[36]) |=> PC_OUT === $past(PC_OUT))
      else $error("program counter moved without step bit");
   a_reset_vals: assert property ($fell(RST)
      |-> MMU_ADDR == `MSQ_POWERUP_UADDR && PC_OUT == `MSQ_POWERUP_PC)
      else $error("wrong values after reset");
   a_slverr_map: assert property (PSEL && PENABLE && PADDR > `MSQ_REG_CC |-> PSLVERR)
      else $error("unmapped access not flagged");
endmodule

// File: msq_seq_tb.sv
// self-checking bench: apb loading of the store, then a four-word program
// assumes msq_seq, msq_dp_model and msq_seq_chk are compiled before it
`include "msq_map.vh"
module msq_seq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] rq;
   logic        re;
   wire  [31:0] prdata, cond_in;
   wire         pready, pslverr, p1, p2, p3, fork_err;
   wire  [15:0] instr, ir_out, pc_out;
   wire  [48:0] ctrl_word;
   wire  [7:0]  mmu_addr;
   wire  [3:0]  cc_out, flags;
   wire  [2:0]  fork_cond;
   wire  [1:0]  cc_sel;
   int          mismatches = 0;
   int          checks_done = 0;
   // 0 -> 05 plain, 05 branch -> 11, 11 fork a -> EA, EA two forks -> 00
   logic [7:0]  ad [4] = '{8'h00, 8'h05, 8'h11, 8'hEA};
   logic [63:0] wd [4] = '{64'hA008_4000_5A5A_0005, 64'h0000_0000_0000_0110,
                           64'h0000_0000_0000_10FF, 64'h0000_0000_0000_3000};
   always #25 clk = ~clk;
   msq_seq u_msq_seq (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .INSTR_DATA(instr), .COND_IN(cond_in), .FORK_COND(fork_cond),
      .ALU_N(flags[3]), .ALU_Z(flags[2]), .ALU_V(flags[1]), .ALU_C(flags[0]),
      .CTRL_WORD(ctrl_word), .PHASE_ONE_PULSE(p1), .PHASE_TWO_PULSE(p2),
      .PHASE_THREE_PULSE(p3), .MMU_ADDR(mmu_addr), .IR_OUT(ir_out), .PC_OUT(pc_out),
      .CC_OUT(cc_out), .CC_SEL(cc_sel), .FORK_ERR(fork_err));
   msq_dp_model u_msq_dp_model (.clk(clk), .pc(pc_out), .cond_pat(32'h0000_0004),
      .fork_pat(3'h1), .instr_data(instr), .cond_in(cond_in), .fork_cond(fork_cond),
      .flags(flags));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         conclude();
      end
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cyc(input logic [7:0] exp_a, input logic exp_err);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (p3 !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         conclude();
      end
      check("fork_err", fork_err, exp_err);
      @(posedge clk);
      #1;
      check("mmu_addr", mmu_addr, exp_a);
   endtask
   task automatic t_regs;
      apb(1'b0, `MSQ_REG_CTRL, 32'h0000_0000);
      check("ctrl reset", rq, `MSQ_CTRL_RESET);
      check("mapped err", re, 1'b0);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      check("unmapped data", rq, 32'h0000_0000);
      check("unmapped err", re, 1'b1);
      apb(1'b0, `MSQ_REG_UC_HI, 32'h0000_0000);
      check("uc_hi read", rq, 32'h0000_0000);
   endtask
   task automatic t_load;
      apb(1'b1, `MSQ_REG_CTRL, 32'h0000_0000);
      foreach (ad[i]) begin
         apb(1'b1, `MSQ_REG_UC_ADDR, {24'h00_0000, ad[i]});
         apb(1'b1, `MSQ_REG_UC_LO, wd[i][31:0]);
         apb(1'b1, `MSQ_REG_UC_HI, wd[i][63:32]);
      end
      // second reset starts the loaded program from the power-up word
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("reset addr", mmu_addr, `MSQ_POWERUP_UADDR);
      check("reset buffer", ctrl_word, 49'h0_0000_0000_0000);
   endtask
   task automatic t_run;
      cyc(8'h05, 1'b0);
      check("pc", pc_out, `MSQ_PC_STEP);
      check("ir", ir_out, 16'h8A00);
      check("cc_sel", cc_sel, 2'h2);
      check("ctrl word", ctrl_word, wd[0][63:15]);
      cyc(8'h11, 1'b0);
      cyc(8'hEA, 1'b0);
      cyc(8'h00, 1'b1);
      // read before the next fetch reloads the instruction registers
      apb(1'b0, `MSQ_REG_CC, 32'h0000_0000);
      check("cc reg", rq, 32'h0000_0020);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_load();
      t_run();
      conclude();
   end
endmodule
bind msq_seq msq_seq_chk u_msq_seq_chk (.CLK, .RST, .PSEL, .PENABLE, .PADDR, .PSLVERR,
   .CTRL_WORD, .PHASE_ONE_PULSE, .PHASE_TWO_PULSE, .PHASE_THREE_PULSE, .MMU_ADDR, .PC_OUT);

// File: msq_store.v
// one slice of the control store: a write port for loading and a read port
// whose data come out of a register; assumes one clock and sync reset
`include "msq_map.vh"
module msq_store #(
   parameter WIDTH  = `MSQ_HALF_W,
   parameter AW     = `MSQ_ADDR_W
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             we,
   input  wire [AW-1:0]    waddr,
   input  wire [WIDTH-1:0] wdata,
   input  wire [AW-1:0]    raddr,
   output reg  [WIDTH-1:0] rdata
);
   reg [WIDTH-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // cleared on reset so fork enables start disabled
   always @(posedge clk) begin
      if (rst) begin
         rdata <= {WIDTH{1'b0}};
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule
